/* ddrpd_pkg.sv */
// constants, command codes and helpers for the ddr2 precharge/refresh/power-down core
// assumes one 10 MHz system clock and pins already synchronous to it
package ddrpd_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int T_RP_NS = 15;
    localparam int T_RFC_NS = 128;
    localparam int T_CKE_CYC = 3;
    localparam int BANKS = 4;
    localparam int CNT_W = 8;
    // {cs, ras, cas, we}
    localparam logic [3:0] ENC_MRS = 4'h0;
    localparam logic [3:0] ENC_REF = 4'h1;
    localparam logic [3:0] ENC_PRE = 4'h2;
    localparam logic [3:0] ENC_ACT = 4'h3;
    localparam logic [3:0] ENC_WR = 4'h4;
    localparam logic [3:0] ENC_RD = 4'h5;
    localparam logic [3:0] ENC_NOP = 4'h7;

    typedef enum logic [2:0] {
        CMD_DSL, CMD_NOP, CMD_ACT, CMD_PRE, CMD_RD, CMD_WR, CMD_MRS, CMD_REF
    } ddrpd_cmd_t;

    typedef enum logic [2:0] {
        ST_RUN, ST_REFRESH, ST_PD_PRE, ST_PD_ACT, ST_SELF
    } ddrpd_state_t;

    // least time rounds up, never below one cycle
    function automatic int cyc_up(input int t_ns);
        int c;
        c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_up

    localparam int T_RP_CYC = cyc_up(T_RP_NS);
    localparam int T_RFC_CYC = cyc_up(T_RFC_NS);

    function automatic ddrpd_cmd_t ddrpd_decode(input logic [3:0] pins);
        ddrpd_cmd_t c;
        c = CMD_NOP;
        if (pins[3]) begin
            c = CMD_DSL;
        end else begin
            unique case (pins)
                ENC_MRS: c = CMD_MRS;
                ENC_REF: c = CMD_REF;
                ENC_PRE: c = CMD_PRE;
                ENC_ACT: c = CMD_ACT;
                ENC_WR: c = CMD_WR;
                ENC_RD: c = CMD_RD;
                default: c = CMD_NOP;
            endcase
        end
        return c;
    endfunction : ddrpd_decode
endpackage : ddrpd_pkg

/* ddrpd_bank.sv */
// one bank's row state, auto-precharge delay and precharge-period timer
// assumes command pulses are already qualified by the decoder
`timescale 1ns/1ps
module ddrpd_bank
    import ddrpd_pkg::*;
#(
    parameter int RD_AP_DLY = 2,
    parameter int WR_AP_DLY = 6,
    parameter int TRP_CYC = 1
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // qualified commands
    input wire logic act_i,
    input wire logic pre_i,
    input wire logic rd_ap_i,
    input wire logic wr_ap_i,
    // state
    output logic open_o,
    output logic prech_o
);
    if (RD_AP_DLY < 1 || WR_AP_DLY < 1 || TRP_CYC < 1 || WR_AP_DLY >= 2**CNT_W) begin : g_chk
        $error("ddrpd_bank: delay out of range");
    end

    logic [CNT_W-1:0] ap_cnt_r;
    logic [CNT_W-1:0] rp_cnt_r;
    logic ap_fire;

    assign ap_fire = (ap_cnt_r == CNT_W'(1));

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ap_cnt_r <= '0;
        end else if (rd_ap_i) begin
            ap_cnt_r <= CNT_W'(RD_AP_DLY);
        end else if (wr_ap_i) begin
            ap_cnt_r <= CNT_W'(WR_AP_DLY);
        end else if (pre_i) begin
            ap_cnt_r <= '0;
        end else if (ap_cnt_r != '0) begin
            ap_cnt_r <= ap_cnt_r - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            open_o <= 1'b0;
        end else if (pre_i || ap_fire) begin
            open_o <= 1'b0;
        end else if (act_i) begin
            open_o <= 1'b1;
        end
    end

    // a later precharge restarts the period rather than stacking on it
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rp_cnt_r <= '0;
            prech_o <= 1'b0;
        end else if (pre_i || ap_fire) begin
            rp_cnt_r <= CNT_W'(TRP_CYC);
            prech_o <= 1'b1;
        end else if (rp_cnt_r != '0) begin
            rp_cnt_r <= rp_cnt_r - CNT_W'(1);
            prech_o <= (rp_cnt_r != CNT_W'(1));
        end
    end

    property p_rp_len;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (pre_i && TRP_CYC == 1) |=> prech_o ##1 (!prech_o || $past(pre_i) || $past(ap_fire));
    endproperty
    a_rp_len: assert property (p_rp_len) else $error("precharge period length wrong");
endmodule : ddrpd_bank

/* ddrpd_core.sv */
// command decode, bank tracking, refresh and power-down state of the memory device
// assumes the controller drives pins synchronous to clk_sys_i and keeps its own spacing
`timescale 1ns/1ps
module ddrpd_core
    import ddrpd_pkg::*;
#(
    parameter int AL = 0,
    parameter int WL = 2,
    parameter int BL = 4,
    parameter int WR = 2,
    parameter bit FAST_EXIT = 1'b1,
    parameter int ROW_W = 13
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    // command pins
    input wire logic cke_i,
    input wire logic cs_b_i,
    input wire logic ras_b_i,
    input wire logic cas_b_i,
    input wire logic we_b_i,
    input wire logic a10_i,
    input wire logic [1:0] ba_i,
    // bank state
    output logic [BANKS-1:0] bank_open_o,
    output logic [BANKS-1:0] bank_prech_o,
    // mode register write
    output logic mrs_wr_o,
    output logic [1:0] mrs_sel_o,
    // refresh
    output logic refresh_busy_o,
    output logic [ROW_W-1:0] refresh_addr_o,
    // power state
    output logic pd_prech_o,
    output logic pd_act_o,
    output logic self_ref_o,
    output logic dll_on_o,
    output logic in_buf_en_o,
    // activity and errors
    output logic burst_busy_o,
    output logic cmd_err_o
);
    // refuse settings the burst and counter logic cannot serve
    if ((BL != 4 && BL != 8) || AL < 0 || WL < 1 || WR < 1 || ROW_W < 1) begin : g_chk
        $error("ddrpd_core: unsupported parameter");
    end

    localparam int RD_AP_DLY = AL + BL / 2;
    localparam int WR_AP_DLY = WL + BL / 2 + WR;
    localparam logic [CNT_W-1:0] BURST_CYC = CNT_W'(BL / 2);
    localparam logic [CNT_W-1:0] RFC_CYC = CNT_W'(T_RFC_CYC);

    ddrpd_state_t st_r;
    ddrpd_state_t st_nxt;
    ddrpd_cmd_t cmd;
    logic cke_prev_r;
    logic [CNT_W-1:0] burst_cnt_r;
    logic [CNT_W-1:0] rfc_cnt_r;
    logic [BANKS-1:0] open_w;
    logic [BANKS-1:0] prech_w;
    logic [BANKS-1:0] act_v;
    logic [BANKS-1:0] pre_v;
    logic [BANKS-1:0] rdap_v;
    logic [BANKS-1:0] wrap_v;
    logic nopdsl;
    logic take;
    logic cke_fall;
    logic cke_rise;
    logic bank_idle;
    logic burst_on;
    logic mrs_run_r;
    logic ref_take;
    logic rw_take;
    logic rw_block;
    logic err_nxt;

    assign cmd = ddrpd_decode({cs_b_i, ras_b_i, cas_b_i, we_b_i});
    assign nopdsl = (cmd == CMD_NOP) || (cmd == CMD_DSL);
    assign cke_fall = cke_prev_r && !cke_i;
    assign cke_rise = !cke_prev_r && cke_i;
    assign take = (st_r == ST_RUN) && cke_prev_r && cke_i;
    assign bank_idle = (open_w == '0) && (prech_w == '0);
    assign burst_on = (burst_cnt_r != '0);
    // short bursts run to their end; a new column command would cut them
    assign rw_block = burst_on && (BL == 4);
    assign rw_take = take && (cmd == CMD_RD || cmd == CMD_WR) && !rw_block
        && open_w[ba_i];
    assign ref_take = take && (cmd == CMD_REF) && bank_idle;

    // per-bank command qualification
    always_comb begin
        act_v = '0;
        pre_v = '0;
        rdap_v = '0;
        wrap_v = '0;
        for (int b = 0; b < BANKS; b++) begin
            if (take && ba_i == 2'(b)) begin
                act_v[b] = (cmd == CMD_ACT) && !open_w[b] && !prech_w[b];
                rdap_v[b] = rw_take && (cmd == CMD_RD) && a10_i;
                wrap_v[b] = rw_take && (cmd == CMD_WR) && a10_i;
            end
            // back-to-back precharges are always taken
            pre_v[b] = take && (cmd == CMD_PRE) && (a10_i || ba_i == 2'(b));
        end
    end

    for (genvar g = 0; g < BANKS; g++) begin : g_bank
        ddrpd_bank #(
            .RD_AP_DLY(RD_AP_DLY),
            .WR_AP_DLY(WR_AP_DLY),
            .TRP_CYC(T_RP_CYC)
        ) u_bank (
            .clk_sys_i(clk_sys_i),
            .rst_b_i(rst_b_i),
            .act_i(act_v[g]),
            .pre_i(pre_v[g]),
            .rd_ap_i(rdap_v[g]),
            .wr_ap_i(wrap_v[g]),
            .open_o(open_w[g]),
            .prech_o(prech_w[g])
        );
    end

    assign bank_open_o = open_w;
    assign bank_prech_o = prech_w;

    // power and refresh state
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            ST_RUN: begin
                if (cke_fall && cmd == CMD_REF && bank_idle) begin
                    st_nxt = ST_SELF;
                end else if (cke_fall && nopdsl) begin
                    st_nxt = (open_w == '0) ? ST_PD_PRE : ST_PD_ACT;
                end else if (ref_take) begin
                    st_nxt = ST_REFRESH;
                end
            end
            ST_REFRESH: begin
                if (rfc_cnt_r == CNT_W'(1)) begin
                    st_nxt = ST_RUN;
                end
            end
            ST_PD_PRE, ST_PD_ACT, ST_SELF: begin
                if (cke_rise && nopdsl) begin
                    st_nxt = ST_RUN;
                end
            end
            default: st_nxt = ST_RUN;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= ST_RUN;
            cke_prev_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cke_prev_r <= cke_i;
        end
    end

    // power outputs follow the next state so they line up with st_r
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pd_prech_o <= 1'b0;
            pd_act_o <= 1'b0;
            self_ref_o <= 1'b0;
            dll_on_o <= 1'b1;
            in_buf_en_o <= 1'b1;
        end else begin
            pd_prech_o <= (st_nxt == ST_PD_PRE);
            pd_act_o <= (st_nxt == ST_PD_ACT);
            self_ref_o <= (st_nxt == ST_SELF);
            dll_on_o <= (st_nxt == ST_RUN) || (st_nxt == ST_REFRESH)
                || (st_nxt == ST_PD_ACT && FAST_EXIT);
            in_buf_en_o <= (st_nxt == ST_RUN) || (st_nxt == ST_REFRESH);
        end
    end

    // refresh timing and internal row counter
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rfc_cnt_r <= '0;
            refresh_busy_o <= 1'b0;
            refresh_addr_o <= '0;
        end else begin
            if (st_r == ST_RUN && st_nxt == ST_REFRESH) begin
                rfc_cnt_r <= RFC_CYC;
                refresh_busy_o <= 1'b1;
                refresh_addr_o <= refresh_addr_o + ROW_W'(1);
            end else if (rfc_cnt_r != '0) begin
                rfc_cnt_r <= rfc_cnt_r - CNT_W'(1);
                refresh_busy_o <= (rfc_cnt_r != CNT_W'(1));
            end
        end
    end

    // burst length tracking; long bursts may be restarted by a new column command
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            burst_cnt_r <= '0;
            burst_busy_o <= 1'b0;
        end else if (rw_take) begin
            burst_cnt_r <= BURST_CYC;
            burst_busy_o <= 1'b1;
        end else if (burst_on) begin
            burst_cnt_r <= burst_cnt_r - CNT_W'(1);
            burst_busy_o <= (burst_cnt_r != CNT_W'(1));
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mrs_wr_o <= 1'b0;
            mrs_sel_o <= 2'h0;
            mrs_run_r <= 1'b0;
        end else begin
            mrs_wr_o <= take && (cmd == CMD_MRS) && bank_idle;
            mrs_run_r <= take && (cmd == CMD_MRS);
            if (take && cmd == CMD_MRS) begin
                mrs_sel_o <= ba_i;
            end
        end
    end

    // illegal sequences are flagged for one cycle; a clock enable fall during a burst or mode write still enters power-down,
    // a mode write refused for a busy bank still loads mrs_sel_o, the rest are ignored
    always_comb begin
        err_nxt = 1'b0;
        if (take && cmd == CMD_REF && !bank_idle) begin
            err_nxt = 1'b1;
        end
        if (take && (cmd == CMD_RD || cmd == CMD_WR) && (rw_block || !open_w[ba_i])) begin
            err_nxt = 1'b1;
        end
        if (take && cmd == CMD_ACT && (open_w[ba_i] || prech_w[ba_i])) begin
            err_nxt = 1'b1;
        end
        if (take && cmd == CMD_MRS && !bank_idle) begin
            err_nxt = 1'b1;
        end
        if (st_r == ST_RUN && cke_fall && (burst_on || mrs_run_r)) begin
            err_nxt = 1'b1;
        end
        if (st_r == ST_RUN && cke_fall && !nopdsl && !(cmd == CMD_REF && bank_idle)) begin
            err_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cmd_err_o <= 1'b0;
        end else begin
            cmd_err_o <= err_nxt;
        end
    end

    property p_pd_entry;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (st_r == ST_RUN && cke_prev_r && !cke_i && nopdsl)
            |=> ((st_r == ST_PD_PRE) == $past(open_w == '0)) && (pd_prech_o || pd_act_o);
    endproperty
    a_pd_entry: assert property (p_pd_entry) else $error("power-down entry wrong");

    property p_pd_hold;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (st_r == ST_PD_PRE && !cke_i) |=> (st_r == ST_PD_PRE) && !in_buf_en_o && !dll_on_o;
    endproperty
    a_pd_hold: assert property (p_pd_hold) else $error("precharge power-down not held");

    property p_pd_exit;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        ((st_r == ST_PD_PRE || st_r == ST_PD_ACT) && !cke_prev_r && cke_i && nopdsl)
            |=> st_r == ST_RUN && in_buf_en_o && dll_on_o;
    endproperty
    a_pd_exit: assert property (p_pd_exit) else $error("power-down exit wrong");

    property p_dll_act;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (st_r == ST_PD_ACT) |-> (dll_on_o == FAST_EXIT) && !in_buf_en_o;
    endproperty
    a_dll_act: assert property (p_dll_act) else $error("dll state in active power-down");

    property p_ref_addr;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        ref_take |=> refresh_busy_o && refresh_addr_o == $past(refresh_addr_o) + ROW_W'(1);
    endproperty
    a_ref_addr: assert property (p_ref_addr) else $error("refresh row not advanced");

    property p_ref_idle;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (take && cmd == CMD_REF && !bank_idle) |=> cmd_err_o && !refresh_busy_o;
    endproperty
    a_ref_idle: assert property (p_ref_idle) else $error("refresh taken while busy");

    property p_self;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (st_r == ST_RUN && cke_fall && cmd == CMD_REF && bank_idle)
            |=> self_ref_o && !refresh_busy_o;
    endproperty
    a_self: assert property (p_self) else $error("self refresh not entered");

    property p_bl4;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (take && cmd == CMD_RD && rw_block) |=> cmd_err_o && $stable(burst_cnt_r) == 1'b0
            && burst_cnt_r == $past(burst_cnt_r) - CNT_W'(1);
    endproperty
    a_bl4: assert property (p_bl4) else $error("short burst interrupted");

    property p_pre_b2b;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (take && cmd == CMD_PRE) ##1 (take && cmd == CMD_PRE && a10_i)
            |=> &prech_w && !cmd_err_o;
    endproperty
    a_pre_b2b: assert property (p_pre_b2b) else $error("back-to-back precharge refused");

    property p_mrs_sel;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (take && cmd == CMD_MRS && bank_idle) |=> mrs_wr_o && mrs_sel_o == $past(ba_i);
    endproperty
    a_mrs_sel: assert property (p_mrs_sel) else $error("mode register select wrong");

    property p_decode;
        @(posedge clk_sys_i) disable iff (!rst_b_i)
        (take && !cs_b_i && !ras_b_i && cas_b_i && we_b_i && !open_w[ba_i] && !prech_w[ba_i])
            |=> bank_open_o[$past(ba_i)];
    endproperty
    a_decode: assert property (p_decode) else $error("activate not decoded");
endmodule : ddrpd_core

/* ddrpd_ctrl_model.sv */
// controller-side model: drives command pins and clock enable of the core
// assumes the core samples every pin on the rising edge of clk_sys_i
`timescale 1ns/1ps
module ddrpd_ctrl_model
    import ddrpd_pkg::*;
#(
    parameter int AL = 0,
    parameter int WL = 2,
    parameter int BL = 4,
    parameter int WR = 2,
    parameter int T_RTP_NS = 8,
    parameter int T_WR_NS = 15
) (
    // clock
    input wire logic clk_sys_i,
    // command pins
    output logic cke_o,
    output logic cs_b_o,
    output logic ras_b_o,
    output logic cas_b_o,
    output logic we_b_o,
    output logic a10_o,
    output logic [1:0] ba_o
);
    // round up so a short analog time never becomes zero cycles
    localparam int RTP_CYC = (T_RTP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_PRE = AL + BL / 2 + ((RTP_CYC > 2) ? RTP_CYC : 2) - 2;
    localparam int WR_PRE = WL + BL / 2 + (T_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRA_PRE = WL + BL / 2 + WR;
    // one generous spacing for all commands: slower, but every minimum is met at once
    localparam int GAP = RD_PRE + WR_PRE + WRA_PRE + T_RP_CYC + T_RFC_CYC + 2;

    initial begin
        cke_o = 1'b1;
        {cs_b_o, ras_b_o, cas_b_o, we_b_o} = ENC_NOP;
        a10_o = 1'b0;
        ba_o = 2'h0;
    end

    // gap 0 lets the next command follow on the very next edge, unless clock enable changes and the gap is raised to T_CKE_CYC
    task automatic cmd(input logic [3:0] enc, input logic ap, input logic [1:0] bank,
                       input logic ck, input int gap);
        if (ck !== cke_o && gap < T_CKE_CYC) gap = T_CKE_CYC;
        @(posedge clk_sys_i);
        {cs_b_o, ras_b_o, cas_b_o, we_b_o} <= enc;
        a10_o <= ap;
        ba_o <= bank;
        cke_o <= ck;
        if (gap > 0) begin
            @(posedge clk_sys_i);
            {cs_b_o, ras_b_o, cas_b_o, we_b_o} <= ENC_NOP;
            // unused address pins flip so a stale value is never mistaken for a hold
            a10_o <= ~ap;
            ba_o <= ~bank;
            repeat (gap - 1) @(posedge clk_sys_i);
        end
    endtask : cmd
endmodule : ddrpd_ctrl_model

/* ddrpd_core_tb_top.sv */
// self-checking bench for the precharge, refresh and power-down core
// assumes ddrpd_ctrl_model drives every command pin of the core
`timescale 1ns/1ps
module ddrpd_core_tb_top
    import ddrpd_pkg::*;
;
    typedef struct {
        logic [3:0] enc;
        logic ap;
        logic [1:0] bank;
        logic [3:0] open;
        int err;
        int mrs;
    } ddrpd_tb_row_t;
    localparam bit FAST = 1'b1;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic cke, cs_b, ras_b, cas_b, we_b, a10;
    logic [1:0] ba;
    logic [3:0] bank_open_o, bank_prech_o;
    logic mrs_wr_o, refresh_busy_o, pd_prech_o, pd_act_o, self_ref_o;
    logic dll_on_o, in_buf_en_o, burst_busy_o, cmd_err_o;
    logic [1:0] mrs_sel_o;
    logic [12:0] refresh_addr_o;
    int error_cnt = 0;
    int checked = 0;
    int err_seen, mrs_seen, pre0_seen;
    int rb_seen = 0;
    ddrpd_tb_row_t rows [13];

    // one fixed rate for the whole run: no frequency change, so no relock is ever owed
    always #50 clk_sys_i = ~clk_sys_i;

    ddrpd_ctrl_model ctl_u (.clk_sys_i(clk_sys_i), .cke_o(cke), .cs_b_o(cs_b),
        .ras_b_o(ras_b), .cas_b_o(cas_b), .we_b_o(we_b), .a10_o(a10), .ba_o(ba));

    ddrpd_core #(.FAST_EXIT(FAST)) dut_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
        .cke_i(cke), .cs_b_i(cs_b), .ras_b_i(ras_b), .cas_b_i(cas_b), .we_b_i(we_b),
        .a10_i(a10), .ba_i(ba), .bank_open_o(bank_open_o), .bank_prech_o(bank_prech_o),
        .mrs_wr_o(mrs_wr_o), .mrs_sel_o(mrs_sel_o), .refresh_busy_o(refresh_busy_o),
        .refresh_addr_o(refresh_addr_o), .pd_prech_o(pd_prech_o), .pd_act_o(pd_act_o),
        .self_ref_o(self_ref_o), .dll_on_o(dll_on_o), .in_buf_en_o(in_buf_en_o),
        .burst_busy_o(burst_busy_o), .cmd_err_o(cmd_err_o));

    // pulses are counted mid-cycle, away from the edge that moves them
    always @(negedge clk_sys_i) begin
        err_seen += (cmd_err_o === 1'b1);
        mrs_seen += (mrs_wr_o === 1'b1);
        pre0_seen += (bank_prech_o[0] === 1'b1);
        rb_seen += (refresh_busy_o === 1'b1);
    end

    task automatic chk_v(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk_v

    task automatic chk_n(input string nm, input int exp, input int got);
        checked++;
        if (got != exp) begin
            error_cnt++;
            $display("mismatch %s expected %0d seen %0d", nm, exp, got);
        end
    endtask : chk_n

    task automatic clr();
        err_seen = 0;
        mrs_seen = 0;
        pre0_seen = 0;
    endtask : clr

    task automatic go(input logic [3:0] enc, input logic ap, input logic [1:0] bank,
                      input logic ck, input int gap);
        ctl_u.cmd(enc, ap, bank, ck, gap);
        if (gap > 0) #10;
    endtask : go

    task automatic give_verdict();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    initial begin
        // the whole run is far shorter than one refresh window
        #(4000 * CLK_PERIOD_NS);
        error_cnt++;
        $display("mismatch watchdog expected done seen hang");
        give_verdict();
    end

    initial begin
        rows = '{
            '{ENC_ACT, 1'b0, 2'h0, 4'h1, 0, 0},
            '{ENC_ACT, 1'b0, 2'h1, 4'h3, 0, 0},
            '{ENC_ACT, 1'b0, 2'h0, 4'h3, 1, 0},
            '{ENC_RD, 1'b1, 2'h1, 4'h1, 0, 0},
            '{ENC_WR, 1'b0, 2'h0, 4'h1, 0, 0},
            '{ENC_PRE, 1'b0, 2'h0, 4'h0, 0, 0},
            '{ENC_RD, 1'b0, 2'h2, 4'h0, 1, 0},
            '{ENC_MRS, 1'b0, 2'h2, 4'h0, 0, 1},
            '{ENC_REF, 1'b0, 2'h0, 4'h0, 0, 0},
            '{4'h8, 1'b0, 2'h0, 4'h0, 0, 0},
            '{ENC_ACT, 1'b0, 2'h3, 4'h8, 0, 0},
            '{ENC_REF, 1'b0, 2'h0, 4'h8, 1, 0},
            '{ENC_WR, 1'b1, 2'h3, 4'h0, 0, 0}
        };
        repeat (6) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        @(posedge clk_sys_i);
        #10;
        chk_v("reset_flags", 16'h0060, {9'h0, dll_on_o, in_buf_en_o, pd_prech_o, pd_act_o,
              self_ref_o, refresh_busy_o, burst_busy_o});
        foreach (rows[i]) begin
            clr();
            go(rows[i].enc, rows[i].ap, rows[i].bank, 1'b1, ctl_u.GAP);
            chk_v("bank_open", {12'h0, rows[i].open}, {12'h0, bank_open_o});
            chk_n("cmd_err", rows[i].err, err_seen);
            chk_n("mrs_wr", rows[i].mrs, mrs_seen);
        end
        chk_v("refresh_addr", 16'h0001, {3'h0, refresh_addr_o});
        chk_n("refresh_busy", T_RFC_CYC, rb_seen);
        go(ENC_ACT, 1'b0, 2'h0, 1'b1, ctl_u.GAP);
        go(ENC_ACT, 1'b0, 2'h1, 1'b1, ctl_u.GAP);
        clr();
        go(ENC_PRE, 1'b0, 2'h0, 1'b1, 0);
        go(ENC_PRE, 1'b1, 2'h2, 1'b1, ctl_u.GAP);
        chk_v("bank_open", 16'h0000, {12'h0, bank_open_o});
        chk_n("cmd_err", 0, err_seen);
        chk_n("prech_cycles", T_RP_CYC + 1, pre0_seen);
        for (int b = 0; b < 4; b++) begin
            clr();
            go(ENC_MRS, 1'b0, b[1:0], 1'b1, ctl_u.GAP);
            chk_v("mrs_sel", {14'h0, b[1:0]}, {14'h0, mrs_sel_o});
            chk_n("mrs_wr", 1, mrs_seen);
        end
        chk_v("dll_locked", 16'h0001, {15'h0, dll_on_o});
        go(ENC_NOP, 1'b0, 2'h0, 1'b0, ctl_u.GAP);
        chk_v("pd_prech", 16'h0004, {13'h0, pd_prech_o, in_buf_en_o, dll_on_o});
        go(ENC_ACT, 1'b0, 2'h0, 1'b0, ctl_u.GAP);
        chk_v("pd_ignore", 16'h0000, {12'h0, bank_open_o});
        go(ENC_NOP, 1'b0, 2'h0, 1'b1, ctl_u.GAP);
        chk_v("pd_exit", 16'h0003, {13'h0, pd_prech_o, in_buf_en_o, dll_on_o});
        go(ENC_ACT, 1'b0, 2'h2, 1'b1, ctl_u.GAP);
        go(ENC_NOP, 1'b0, 2'h0, 1'b0, ctl_u.GAP);
        chk_v("pd_act", {13'h0, 2'b10, FAST}, {13'h0, pd_act_o, in_buf_en_o, dll_on_o});
        go(ENC_NOP, 1'b0, 2'h0, 1'b1, ctl_u.GAP);
        chk_v("pd_act_exit", 16'h0003, {13'h0, pd_act_o, in_buf_en_o, dll_on_o});
        clr();
        go(ENC_RD, 1'b0, 2'h2, 1'b1, 0);
        go(ENC_RD, 1'b0, 2'h2, 1'b1, ctl_u.GAP);
        chk_n("burst_cut", 1, err_seen);
        clr();
        go(ENC_RD, 1'b0, 2'h2, 1'b1, 0);
        go(ENC_NOP, 1'b0, 2'h0, 1'b0, ctl_u.GAP);
        chk_n("burst_pd", 1, err_seen);
        // the core only flags the early clock enable fall; power-down still follows
        chk_v("burst_pd_state", 16'h0001, {15'h0, pd_act_o});
        go(ENC_NOP, 1'b0, 2'h0, 1'b1, ctl_u.GAP);
        go(ENC_PRE, 1'b1, 2'h0, 1'b1, ctl_u.GAP);
        go(ENC_REF, 1'b0, 2'h0, 1'b0, ctl_u.GAP);
        chk_v("self_ref", 16'h0001, {15'h0, self_ref_o});
        go(ENC_NOP, 1'b0, 2'h0, 1'b1, ctl_u.GAP);
        chk_v("self_exit", 16'h0000, {15'h0, self_ref_o});
        go(ENC_ACT, 1'b0, 2'h1, 1'b1, ctl_u.GAP);
        @(posedge clk_sys_i);
        rst_b_i <= 1'b0;
        #10;
        chk_v("mid_reset", 16'h0018, {6'h0, bank_open_o, refresh_addr_o[0], dll_on_o,
              in_buf_en_o, pd_prech_o, pd_act_o, self_ref_o});
        repeat (2) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        go(ENC_ACT, 1'b0, 2'h0, 1'b1, ctl_u.GAP);
        chk_v("reset_act", 16'h0001, {12'h0, bank_open_o});
        give_verdict();
    end
endmodule : ddrpd_core_tb_top
